//--- src/irq_sub_regs.svh
// Purpose: register offsets, field positions and timing counts
// Assumes: 32-bit AXI4-Lite words, one register per aligned word
// Notes: definitions only
`ifndef IRQ_SUB_REGS_SVH
`define IRQ_SUB_REGS_SVH

`define OFF_LV_CTRL 8'h00
`define OFF_IRQ_CTRL 8'h04
`define OFF_FLAGS 8'h08
`define OFF_STATUS 8'h0C

`define LVC_DETECTED 5
`define LVC_DET_EN 4
`define LVC_REF_BUF 3
`define LVC_LEVEL_LSB 0
`define LVC_RESET 8'h00

`define CTL_GIE 0
`define CTL_NV_EN 1
`define CTL_LV_EN 2
`define CTL_MFE_LSB 3
`define CTL_TM_LSB 8

`define FLG_NV 0
`define FLG_LV 1
`define FLG_MFF_LSB 2
`define FLG_TM_LSB 8

`define ST_SETTLED 0
`define ST_REF_ON 1
`define ST_DET_ON 2

`define MF_NV_LV 0
`define MF_TM 1

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_PERIOD_NS 100
`define LV_SETTLE_NS 2000
`define LV_DELAY_NS 500
`define LV_SETTLE_CYC ((`LV_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LV_DELAY_CYC ((`LV_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define LV_MV_0 16'h07D0
`define LV_MV_1 16'h0898
`define LV_MV_2 16'h0960
`define LV_MV_3 16'h0A8C
`define LV_MV_4 16'h0BB8
`define LV_MV_5 16'h0CE4
`define LV_MV_6 16'h0E10
`define LV_MV_7 16'h0FA0

`endif

//--- src/irq_sub_pkg.sv
// Purpose: shared types of the interrupt sub-block
// Assumes: nothing
// Notes: constants live in irq_sub_regs.svh
package irq_sub_pkg;
  typedef enum logic [1:0] {st_off, st_settling, st_active} lv_state_t;
  typedef logic [1:0] axi_resp_t;
endpackage

//--- src/req_flag_cell.sv
// Purpose: one sticky interrupt request flag
// Assumes: all inputs synchronous to aclk
// Notes: hardware set beats both software write and hardware clear
`timescale 1ns/10ps
module req_flag_cell (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hw_set,
  input wire logic hw_clr,
  input wire logic sw_we,
  input wire logic sw_val,
  output logic flag,
  output logic rose
);
  logic flag_nxt;

  // Set wins so an event in the clearing cycle survives
  always_comb begin
    if (hw_set) begin
      flag_nxt = 1'b1;
    end else if (sw_we) begin
      flag_nxt = sw_val;
    end else if (hw_clr) begin
      flag_nxt = 1'b0;
    end else begin
      flag_nxt = flag;
    end
  end

  assign rose = flag_nxt & ~flag;

  // Flag holds until serviced or cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else begin
      flag <= flag_nxt;
    end
  end
endmodule // req_flag_cell

//--- src/irq_sub_ctrl.sv
// Purpose: multi-function interrupt requests, wake-up and low-voltage detector control
// Assumes: core and analog inputs synchronous to aclk, AXI4-Lite register access
// Notes:
// Overview of operation
// - Write-complete flag sets when a nonvolatile write cycle finishes.
// - Write-complete request needs global, source and group enables, stack not full.
// - Servicing clears global enable and group flag; source flag stays set.
// - Each timer module has two request flags and two enables.
// - Period, compare A or compare B match sets a timer flag.
// - Timer service clears global enable and its group flag only.
// - Any request flag rising wakes the device, whatever the enables.
// - Pending flags survive disabled enables until serviced or cleared.
// - Interrupt entry pushes only the program counter.
// - Return-from-interrupt sets global enable; plain return leaves it clear.
// - Control register: detected bit 5, enable 4, buffer 3, level 2..0.
// - Level code picks threshold 2.0V up to 4.0V in eight steps.
// - Enabled detector shows supply below threshold as detected flag.
// - Clearing enable stops detector; enabled detector runs while powered down.
// - Reference runs when detector, low-voltage reset or buffer bit enabled.
// - Low-voltage flag sets only after a fixed delay of detection.
// - Flag logic tolerates repeated toggling of the detected flag.
// - Powered-down drop below threshold sets flag and wakes the device.
// - A group flag sets whenever any of its source flags sets.
`timescale 1ns/10ps
`include "irq_sub_regs.svh"
module irq_sub_ctrl #(
  parameter int NUM_TM = 2,
  parameter int SETTLE_CYC = `LV_SETTLE_CYC,
  parameter int DELAY_CYC = `LV_DELAY_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic nv_write_done,
  input wire logic [NUM_TM-1:0] tm_cmp_p,
  input wire logic [NUM_TM-1:0] tm_cmp_a,
  input wire logic [NUM_TM-1:0] tm_cmp_b,
  input wire logic supply_below,
  input wire logic low_volt_reset_en,
  input wire logic low_power,
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic irq_ack_group,
  input wire logic return_from_irq,
  output logic [1:0] irq_req,
  output logic push_pc,
  output logic wake_up,
  output logic low_volt_detector_en,
  output logic reference_en,
  output logic [2:0] low_volt_level_sel,
  output logic [15:0] threshold_mv
);
  localparam int NT = 2 * NUM_TM;
  localparam int CW = 16;

  // Bus state
  logic aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire, wr_map;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;

  // Control state
  logic global_irq_en_r, nv_write_done_irq_en_r, low_volt_irq_en_r;
  logic [1:0] multi_irq_en_r;
  logic [NT-1:0] tm_irq_en_r;
  logic lv_det_en_r, ref_buf_r;
  logic [2:0] level_r;
  irq_sub_pkg::lv_state_t lv_state_r;
  logic [CW-1:0] settle_cnt_r, delay_cnt_r;
  logic low_volt_detected_r, lv_set;

  // Flags
  logic nv_write_done_flag, low_volt_irq_flag;
  logic [NT-1:0] tm_flag, tm_set, tm_rose;
  logic [1:0] multi_irq_flag, mff_rose, grp_rose, grp_pend, ack_clr;
  logic nv_rose, lv_rose, any_rose;

  // Write decode, one register word per offset
  logic wr_lvc, wr_ctl_lo, wr_ctl_hi, wr_flg_lo, wr_flg_hi;
  assign wr_fire = aw_hold_r & w_hold_r & ~s_bvalid;
  assign wr_lvc = wr_fire & (aw_addr_r == `OFF_LV_CTRL) & w_strb_r[0];
  assign wr_ctl_lo = wr_fire & (aw_addr_r == `OFF_IRQ_CTRL) & w_strb_r[0];
  assign wr_ctl_hi = wr_fire & (aw_addr_r == `OFF_IRQ_CTRL) & w_strb_r[1];
  assign wr_flg_lo = wr_fire & (aw_addr_r == `OFF_FLAGS) & w_strb_r[0];
  assign wr_flg_hi = wr_fire & (aw_addr_r == `OFF_FLAGS) & w_strb_r[1];
  assign wr_map = (aw_addr_r == `OFF_LV_CTRL) | (aw_addr_r == `OFF_IRQ_CTRL) |
    (aw_addr_r == `OFF_FLAGS) | (aw_addr_r == `OFF_STATUS);

  // Write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= `RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_awaddr[7:2], 2'b00};
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // Read mux, unused and reserved bits read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = `RESP_OKAY;
    case ({s_araddr[7:2], 2'b00})
      `OFF_LV_CTRL: begin
        rdata_nxt[`LVC_DETECTED] = low_volt_detected_r;
        rdata_nxt[`LVC_DET_EN] = lv_det_en_r;
        rdata_nxt[`LVC_REF_BUF] = ref_buf_r;
        rdata_nxt[`LVC_LEVEL_LSB +: 3] = level_r;
      end
      `OFF_IRQ_CTRL: begin
        rdata_nxt[`CTL_GIE] = global_irq_en_r;
        rdata_nxt[`CTL_NV_EN] = nv_write_done_irq_en_r;
        rdata_nxt[`CTL_LV_EN] = low_volt_irq_en_r;
        rdata_nxt[`CTL_MFE_LSB +: 2] = multi_irq_en_r;
        rdata_nxt[`CTL_TM_LSB +: NT] = tm_irq_en_r;
      end
      `OFF_FLAGS: begin
        rdata_nxt[`FLG_NV] = nv_write_done_flag;
        rdata_nxt[`FLG_LV] = low_volt_irq_flag;
        rdata_nxt[`FLG_MFF_LSB +: 2] = multi_irq_flag;
        rdata_nxt[`FLG_TM_LSB +: NT] = tm_flag;
      end
      `OFF_STATUS: begin
        rdata_nxt[`ST_SETTLED] = (lv_state_r == irq_sub_pkg::st_active);
        rdata_nxt[`ST_REF_ON] = reference_en;
        rdata_nxt[`ST_DET_ON] = low_volt_detector_en;
      end
      default: begin
        rresp_nxt = `RESP_SLVERR;
      end
    endcase
  end

  // Read channel, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rdata_nxt;
      s_rresp <= rresp_nxt;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // Global enable: service clears, return sets, then software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_en_r <= 1'b0;
    end else if (irq_ack) begin
      global_irq_en_r <= 1'b0;
    end else if (return_from_irq) begin
      global_irq_en_r <= 1'b1;
    end else if (wr_ctl_lo) begin
      global_irq_en_r <= w_data_r[`CTL_GIE];
    end
  end

  // Source and group enables, software only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_write_done_irq_en_r <= 1'b0;
      low_volt_irq_en_r <= 1'b0;
      multi_irq_en_r <= 2'b00;
      tm_irq_en_r <= '0;
    end else begin
      if (wr_ctl_lo) begin
        nv_write_done_irq_en_r <= w_data_r[`CTL_NV_EN];
        low_volt_irq_en_r <= w_data_r[`CTL_LV_EN];
        multi_irq_en_r <= w_data_r[`CTL_MFE_LSB +: 2];
      end
      if (wr_ctl_hi) begin
        tm_irq_en_r <= w_data_r[`CTL_TM_LSB +: NT];
      end
    end
  end

  // Detector control byte; detected bit is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {lv_det_en_r, ref_buf_r, level_r} <= 5'(`LVC_RESET);
    end else if (wr_lvc) begin
      lv_det_en_r <= w_data_r[`LVC_DET_EN];
      ref_buf_r <= w_data_r[`LVC_REF_BUF];
      level_r <= w_data_r[`LVC_LEVEL_LSB +: 3];
    end
  end

  // Settling tracker; no gating by low_power so it runs powered down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lv_state_r <= irq_sub_pkg::st_off;
      settle_cnt_r <= '0;
    end else begin
      case (lv_state_r)
        irq_sub_pkg::st_off: begin
          settle_cnt_r <= '0;
          if (lv_det_en_r) begin
            lv_state_r <= irq_sub_pkg::st_settling;
          end
        end
        irq_sub_pkg::st_settling: begin
          if (!lv_det_en_r) begin
            lv_state_r <= irq_sub_pkg::st_off;
          end else if (settle_cnt_r == CW'(SETTLE_CYC - 1)) begin
            lv_state_r <= irq_sub_pkg::st_active;
          end else begin
            settle_cnt_r <= settle_cnt_r + 1'b1;
          end
        end
        irq_sub_pkg::st_active: begin
          if (!lv_det_en_r) begin
            lv_state_r <= irq_sub_pkg::st_off;
          end
        end
        default: begin
          lv_state_r <= irq_sub_pkg::st_off;
        end
      endcase
    end
  end

  // Detected flag follows the comparator only while enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_volt_detected_r <= 1'b0;
    end else begin
      low_volt_detected_r <= lv_det_en_r & supply_below;
    end
  end

  // Delay counter restarts on every drop, so toggling near threshold is harmless
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_cnt_r <= '0;
    end else if (!low_volt_detected_r) begin
      delay_cnt_r <= '0;
    end else if (delay_cnt_r != CW'(DELAY_CYC)) begin
      delay_cnt_r <= delay_cnt_r + 1'b1;
    end
  end
  assign lv_set = low_volt_detected_r & (delay_cnt_r == CW'(DELAY_CYC - 1));

  // Analog-facing outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_volt_detector_en <= 1'b0;
      reference_en <= 1'b0;
      low_volt_level_sel <= 3'h0;
      threshold_mv <= `LV_MV_0;
    end else begin
      low_volt_detector_en <= lv_det_en_r;
      reference_en <= lv_det_en_r | low_volt_reset_en | ref_buf_r;
      low_volt_level_sel <= level_r;
      case (level_r)
        3'h0: threshold_mv <= `LV_MV_0;
        3'h1: threshold_mv <= `LV_MV_1;
        3'h2: threshold_mv <= `LV_MV_2;
        3'h3: threshold_mv <= `LV_MV_3;
        3'h4: threshold_mv <= `LV_MV_4;
        3'h5: threshold_mv <= `LV_MV_5;
        3'h6: threshold_mv <= `LV_MV_6;
        default: threshold_mv <= `LV_MV_7;
      endcase
    end
  end

  // Source flags; software may set them high to mask wake-up
  req_flag_cell u_nv_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .hw_set(nv_write_done),
    .hw_clr(1'b0),
    .sw_we(wr_flg_lo),
    .sw_val(w_data_r[`FLG_NV]),
    .flag(nv_write_done_flag),
    .rose(nv_rose)
  );

  req_flag_cell u_lv_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .hw_set(lv_set),
    .hw_clr(1'b0),
    .sw_we(wr_flg_lo),
    .sw_val(w_data_r[`FLG_LV]),
    .flag(low_volt_irq_flag),
    .rose(lv_rose)
  );

  // Two flags per timer: A match, and period or B match
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TM; gi = gi + 1) begin : g_tm
      assign tm_set[2*gi] = tm_cmp_a[gi];
      assign tm_set[2*gi+1] = tm_cmp_p[gi] | tm_cmp_b[gi];
    end
    for (gi = 0; gi < NT; gi = gi + 1) begin : g_tm_flag
      req_flag_cell u_tm_flag (
        .aclk(aclk),
        .aresetn(aresetn),
        .hw_set(tm_set[gi]),
        .hw_clr(1'b0),
        .sw_we(wr_flg_hi),
        .sw_val(w_data_r[`FLG_TM_LSB + gi]),
        .flag(tm_flag[gi]),
        .rose(tm_rose[gi])
      );
    end
  endgenerate

  // Group flags set on any member rising, cleared by service
  assign grp_rose[`MF_NV_LV] = nv_rose | lv_rose;
  assign grp_rose[`MF_TM] = |tm_rose;
  assign ack_clr[`MF_NV_LV] = irq_ack & (irq_ack_group == 1'b0);
  assign ack_clr[`MF_TM] = irq_ack & (irq_ack_group == 1'b1);
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_mff
      req_flag_cell u_mff (
        .aclk(aclk),
        .aresetn(aresetn),
        .hw_set(grp_rose[gi]),
        .hw_clr(ack_clr[gi]),
        .sw_we(wr_flg_lo),
        .sw_val(w_data_r[`FLG_MFF_LSB + gi]),
        .flag(multi_irq_flag[gi]),
        .rose(mff_rose[gi])
      );
    end
  endgenerate

  // Pending work per group; enables only block, never erase
  assign grp_pend[`MF_NV_LV] = (nv_write_done_flag & nv_write_done_irq_en_r) |
    (low_volt_irq_flag & low_volt_irq_en_r);
  assign grp_pend[`MF_TM] = |(tm_flag & tm_irq_en_r);

  // Vector requests, dropped in the service cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 2'b00;
    end else begin
      irq_req <= {2{global_irq_en_r & ~stack_full & ~irq_ack}} &
        multi_irq_en_r & multi_irq_flag & grp_pend;
    end
  end

  // Entry saves the program counter and nothing else
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      push_pc <= 1'b0;
    end else begin
      push_pc <= irq_ack;
    end
  end

  // Wake on any rising flag, independent of enables
  assign any_rose = nv_rose | lv_rose | (|tm_rose) | (|mff_rose);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= low_power & any_rose;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ack_clears_gie: assert property (irq_ack |=> !global_irq_en_r)
    else $error("global enable not cleared by service");
  a_ack_keeps_src: assert property (
    irq_ack && nv_write_done_flag && !wr_flg_lo |=> nv_write_done_flag)
    else $error("source flag lost on service");
  a_tm_src_kept: assert property (
    irq_ack && tm_flag[0] && !wr_flg_hi |=> tm_flag[0])
    else $error("timer flag lost on service");
  a_rfi_sets_gie: assert property (
    return_from_irq && !irq_ack |=> global_irq_en_r)
    else $error("return did not set global enable");
  a_nv_flag_set: assert property (nv_write_done |=> nv_write_done_flag)
    else $error("write-complete flag not set");
  a_tm_match_set: assert property (
    tm_cmp_p[0] || tm_cmp_b[0] |=> tm_flag[1])
    else $error("timer flag not set on match");
  a_req_needs_gie: assert property (
    irq_req[`MF_TM] |-> $past(global_irq_en_r) && $past(multi_irq_flag[`MF_TM]))
    else $error("request without enable");
  a_stack_blocks: assert property (stack_full |=> irq_req == 2'b00)
    else $error("request while stack full");
  a_wake_on_rise: assert property (
    low_power && nv_write_done && !nv_write_done_flag |=> wake_up)
    else $error("no wake on rising flag");
  a_group_follows: assert property (
    $rose(tm_flag[0]) |-> multi_irq_flag[`MF_TM] || $past(ack_clr[`MF_TM]))
    else $error("group flag missed member");
  a_det_off: assert property (!lv_det_en_r |=> !low_volt_detected_r)
    else $error("detected flag while disabled");
  a_lv_delay: assert property (
    lv_set |-> low_volt_detected_r && $past(low_volt_detected_r))
    else $error("low-voltage flag set without held detection");
  a_ref_enable: assert property (
    ref_buf_r |=> reference_en)
    else $error("reference off with buffer bit set");
  a_pc_push: assert property (irq_ack |=> push_pc ##1 !push_pc)
    else $error("entry push not a single pulse");

  c_service: cover property (irq_req[`MF_NV_LV] ##1 irq_ack ##1 return_from_irq);
  c_lv_wake: cover property (low_power && lv_set ##1 wake_up);
  c_tm_req: cover property ($rose(irq_req[`MF_TM]));
endmodule // irq_sub_ctrl

//--- bench/subirq_wakeup_lowvolt_detect_test.sv
// Purpose: self-checking bench for the interrupt request and low-voltage block
// Assumes: AXI4-Lite register map and timing as in the design hand-over
// Notes: short settle and delay counts keep the run brief
`timescale 1ns/10ps
`include "irq_sub_regs.svh"
module subirq_wakeup_lowvolt_detect_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, push_pc, wake_up;
  logic [1:0] bresp, rresp, irq_req;
  logic nv_write_done = 1'b0, supply_below = 1'b0, lvr_en = 1'b0, low_power = 1'b0;
  logic stack_full = 1'b0, irq_ack = 1'b0, ack_grp = 1'b0, ret_irq = 1'b0;
  logic [1:0] cmp_p = 2'h0, cmp_a = 2'h0, cmp_b = 2'h0;
  logic det_en, ref_en;
  logic [2:0] level;
  logic [15:0] thr_mv;
  logic [15:0] mv_tab [8] = '{16'h07D0, 16'h0898, 16'h0960, 16'h0A8C,
                              16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0};
  int mismatches = 0, checks_done = 0, cycles = 0, wakes = 0, pushes = 0, w0, p0;

  irq_sub_ctrl #(.NUM_TM(2), .SETTLE_CYC(2), .DELAY_CYC(2)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .nv_write_done(nv_write_done),
    .tm_cmp_p(cmp_p), .tm_cmp_a(cmp_a), .tm_cmp_b(cmp_b), .supply_below(supply_below),
    .low_volt_reset_en(lvr_en), .low_power(low_power), .stack_full(stack_full),
    .irq_ack(irq_ack), .irq_ack_group(ack_grp), .return_from_irq(ret_irq),
    .irq_req(irq_req), .push_pc(push_pc), .wake_up(wake_up),
    .low_volt_detector_en(det_en), .reference_en(ref_en),
    .low_volt_level_sel(level), .threshold_mv(thr_mv)
  );

  // Clock and hang guard
  always #50 aclk = ~aclk;

  // Pulses counted mid-cycle, so a snapshot taken at an edge never races them
  always @(negedge aclk) begin
    if (wake_up === 1'b1) wakes++;
    if (push_pc === 1'b1) pushes++;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        done = 1'b1;
        check({30'h0, bresp}, {30'h0, er});
      end
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        done = 1'b1;
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, er});
      end
    end
  endtask

  task automatic ack(input logic g);
    p0 = pushes;
    @(posedge aclk);
    irq_ack <= 1'b1;
    ack_grp <= g;
    @(posedge aclk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge aclk);
    check(pushes, p0 + 1);
    check({30'h0, irq_req}, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`OFF_LV_CTRL, 32'h0, `RESP_OKAY);
    check({16'h0, thr_mv}, 32'h07D0);
    // Unmapped place answers with an error and holds nothing
    axi_wr(8'h10, 32'hFF, `RESP_SLVERR);
    rd_chk(8'h10, 32'h0, `RESP_SLVERR);
    // Upper and read-only bits ignore writes
    axi_wr(`OFF_LV_CTRL, 32'hFFFFFFFF, `RESP_OKAY);
    rd_chk(`OFF_LV_CTRL, 32'h1F, `RESP_OKAY);
    check({30'h0, det_en, ref_en}, 32'h3);
    // Every level code against its threshold, detector off
    for (int i = 0; i < 8; i++) begin
      axi_wr(`OFF_LV_CTRL, i, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      check({16'h0, thr_mv}, {16'h0, mv_tab[i]});
      check({27'h0, level, det_en, ref_en}, {27'h0, i[2:0], 2'b00});
    end
    axi_wr(`OFF_LV_CTRL, 32'h08, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({31'h0, ref_en}, 32'h1);
    axi_wr(`OFF_LV_CTRL, 32'h00, `RESP_OKAY);
    lvr_en <= 1'b1;
    repeat (2) @(posedge aclk);
    check({31'h0, ref_en}, 32'h1);
    lvr_en <= 1'b0;
    axi_wr(`OFF_STATUS, 32'h7, `RESP_OKAY);
    rd_chk(`OFF_STATUS, 32'h0, `RESP_OKAY);
    // Device powered down, detector on: short dip is not flagged, a held one is
    low_power <= 1'b1;
    axi_wr(`OFF_LV_CTRL, 32'h10, `RESP_OKAY);
    rd_chk(`OFF_STATUS, 32'h6, `RESP_OKAY);
    rd_chk(`OFF_STATUS, 32'h7, `RESP_OKAY);
    w0 = wakes;
    @(posedge aclk);
    supply_below <= 1'b1;
    @(posedge aclk);
    supply_below <= 1'b0;
    rd_chk(`OFF_FLAGS, 32'h0, `RESP_OKAY);
    check(wakes, w0);
    supply_below <= 1'b1;
    rd_chk(`OFF_LV_CTRL, 32'h30, `RESP_OKAY);
    rd_chk(`OFF_FLAGS, 32'h6, `RESP_OKAY);
    check({31'h0, wakes > w0}, 32'h1);
    supply_below <= 1'b0;
    rd_chk(`OFF_LV_CTRL, 32'h10, `RESP_OKAY);
    // Pending flags survive disabled enables
    axi_wr(`OFF_IRQ_CTRL, 32'h0, `RESP_OKAY);
    rd_chk(`OFF_FLAGS, 32'h6, `RESP_OKAY);
    // A flag already high gives no wake on a new event
    axi_wr(`OFF_FLAGS, 32'h1, `RESP_OKAY);
    w0 = wakes;
    @(posedge aclk);
    nv_write_done <= 1'b1;
    @(posedge aclk);
    nv_write_done <= 1'b0;
    repeat (3) @(posedge aclk);
    check(wakes, w0);
    axi_wr(`OFF_FLAGS, 32'h0, `RESP_OKAY);
    w0 = wakes;
    @(posedge aclk);
    nv_write_done <= 1'b1;
    @(posedge aclk);
    nv_write_done <= 1'b0;
    rd_chk(`OFF_FLAGS, 32'h5, `RESP_OKAY);
    check({31'h0, wakes > w0}, 32'h1);
    // Vectoring needs all enables and room on the stack
    axi_wr(`OFF_IRQ_CTRL, 32'h09, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({30'h0, irq_req}, 32'h0);
    stack_full <= 1'b1;
    axi_wr(`OFF_IRQ_CTRL, 32'h0B, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({30'h0, irq_req}, 32'h0);
    stack_full <= 1'b0;
    repeat (2) @(posedge aclk);
    check({30'h0, irq_req}, 32'h1);
    ack(1'b0);
    rd_chk(`OFF_IRQ_CTRL, 32'h0A, `RESP_OKAY);
    rd_chk(`OFF_FLAGS, 32'h1, `RESP_OKAY);
    @(posedge aclk);
    ret_irq <= 1'b1;
    @(posedge aclk);
    ret_irq <= 1'b0;
    rd_chk(`OFF_IRQ_CTRL, 32'h0B, `RESP_OKAY);
    // Timer matches of all three comparators, then a timer service
    axi_wr(`OFF_FLAGS, 32'h0, `RESP_OKAY);
    @(posedge aclk);
    cmp_p <= 2'b01;
    cmp_a <= 2'b11;
    nv_write_done <= 1'b1;
    @(posedge aclk);
    cmp_p <= 2'b00;
    cmp_a <= 2'b00;
    nv_write_done <= 1'b0;
    cmp_b <= 2'b10;
    @(posedge aclk);
    cmp_b <= 2'b00;
    rd_chk(`OFF_FLAGS, 32'hF0D, `RESP_OKAY);
    axi_wr(`OFF_IRQ_CTRL, 32'hF11, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({30'h0, irq_req}, 32'h2);
    ack(1'b1);
    rd_chk(`OFF_FLAGS, 32'hF05, `RESP_OKAY);
    rd_chk(`OFF_IRQ_CTRL, 32'hF10, `RESP_OKAY);
    final_report();
  end
endmodule // subirq_wakeup_lowvolt_detect_test
